// ==== common/sot_pkg.sv ====
// constants, register map and carrier types of the secondary osc timer
// assumes a 50 MHz system clock and an APB master with 32-bit data
package sot_pkg;

   localparam int SYNC_STAGES = 3;
   localparam int PRESC_W = 3;

   // register byte offsets
   localparam logic [7:0] OFF_CTRL = 8'h00;
   localparam logic [7:0] OFF_CNT_LO = 8'h04;
   localparam logic [7:0] OFF_CNT_HI = 8'h08;
   localparam logic [7:0] OFF_FLAG = 8'h0c;
   localparam logic [7:0] OFF_IEN = 8'h10;
   localparam logic [7:0] OFF_OSCCTL = 8'h14;
   localparam logic [7:0] OFF_CMPMODE = 8'h18;
   localparam logic [7:0] OFF_CMPVAL = 8'h1c;

   // counter_control_register fields
   localparam int CB_ON = 0;
   localparam int CB_SRC = 1;
   localparam int CB_NOSYNC = 2;
   localparam int CB_OSCEN = 3;
   localparam int CB_PS = 4;
   localparam int CB_ACT = 6;
   localparam int CB_WIDE = 7;
   // osc_control_register fields, then the flag register field
   localparam int OB_SCS = 0;
   localparam int OB_IDLE = 7;
   localparam int FB_OVF = 0;

   localparam logic [1:0] SCS_SECONDARY = 2'h1;
   localparam logic [3:0] CMP_SPECIAL = 4'hb;
   localparam logic [15:0] COUNT_MAX = 16'hffff;
   localparam logic [15:0] COUNT_ZERO = 16'h0000;

   typedef enum logic [3:0] {
      MODE_PRI = 4'b0001,
      MODE_SEC_RUN = 4'b0010,
      MODE_SEC_IDLE = 4'b0100,
      MODE_SLEEP = 4'b1000
   } sot_mode_e;

   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [7:0] paddr;
      logic [31:0] pwdata;
   } sot_apb_req_s;

   typedef struct packed {
      logic pready;
      logic pslverr;
      logic [31:0] prdata;
   } sot_apb_rsp_s;

endpackage

// ==== rtl/sot_pin_sync.sv ====
// three-stage synchroniser with agreement filter and rise strobe
// assumes the input is asynchronous to clk_sys
module sot_pin_sync
   import sot_pkg::*;
#(
   parameter int STAGES = SYNC_STAGES
)
(
   // system
   input wire logic clk_sys,
   input wire logic reset_n,
   // pin side
   input wire logic pinAsync,
   // synchronised side
   output logic pinLevel,
   output logic pinRise
);

   if (STAGES < 3)
   begin : g_chk
      $error("sot_pin_sync needs at least three stages");
   end

   typedef struct packed {
      logic [STAGES-1:0] shift;
      logic level;
   } sot_sync_s;

   sot_sync_s st;
   sot_sync_s next_st;
   logic agree;

   // the first stage feeds only the second one
   assign agree = st.shift[1] == st.shift[2];

   always_comb
   begin
      next_st = st;
      next_st.shift = {st.shift[STAGES-2:0], pinAsync};
      if (agree)
      begin
         next_st.level = st.shift[2];
      end
   end

   always_ff @(posedge clk_sys or negedge reset_n)
   begin
      if (!reset_n)
      begin
         st <= '0;
      end
      else
      begin
         st <= next_st;
      end
   end

   assign pinLevel = st.level;
   assign pinRise = agree && st.shift[2] && !st.level;

endmodule

// ==== rtl/sot_prescaler.sv ====
// input prescaler: divides count ticks by 1, 2, 4 or 8
// assumes tickIn is a one-cycle strobe on clk_sys
module sot_prescaler
   import sot_pkg::*;
#(
   parameter int WIDTH = PRESC_W
)
(
   // system
   input wire logic clk_sys,
   input wire logic reset_n,
   // control
   input wire logic clear,
   input wire logic [1:0] divSel,
   // ticks
   input wire logic tickIn,
   output logic tickOut
);

   if (WIDTH < 3)
   begin : g_chk
      $error("sot_prescaler needs three bits for divide by eight");
   end

   typedef struct packed {
      logic [WIDTH-1:0] cnt;
   } sot_presc_s;

   sot_presc_s st;
   sot_presc_s next_st;
   logic [WIDTH-1:0] lastVal;

   assign lastVal = WIDTH'((1 << divSel) - 1);
   assign tickOut = tickIn && (st.cnt >= lastVal);

   always_comb
   begin
      next_st = st;
      if (clear)
      begin
         next_st.cnt = '0;
      end
      else if (tickOut)
      begin
         next_st.cnt = '0;
      end
      else if (tickIn)
      begin
         next_st.cnt = st.cnt + WIDTH'(1);
      end
   end

   always_ff @(posedge clk_sys or negedge reset_n)
   begin
      if (!reset_n)
      begin
         st <= '0;
      end
      else
      begin
         st <= next_st;
      end
   end

endmodule

// ==== rtl/sot_timer.sv ====
// secondary oscillator timer: 16-bit counter, overflow flag,
// compare special event clear, clock mode control, APB registers
// assumes clk_sys is the instruction clock and pins are asynchronous
//
// Behaviour
// RULE1: oscillator runs only while osc_enable_bit is set
// RULE2: oscillator stays on through every power-managed mode
// RULE3: system_clock_select 01 enters secondary run mode
// RULE4: sleep in secondary run with idle bit clear enters secondary idle
// RULE5: active flag reads 1 only while secondary clock drives the system
// RULE6: low_power_osc_config set gives low power, default higher power
// RULE7: count runs 0000h to FFFFh and wraps to 0000h
// RULE8: each wrap sets overflow_flag until software clears it
// RULE9: interrupt request only while overflow_int_enable is set
// RULE10: compare mode 1011 match clears the count
// RULE11: the same trigger starts a conversion if converter enabled
// RULE12: trigger clear not relied on in asynchronous counter mode
// RULE13: compare value acts as period, count restarts at zero
// RULE14: count write in trigger cycle wins over the clear
// RULE15: trigger clear never sets overflow_flag
// RULE16: software waits for oscillator start-up before use
// RULE17: source bit picks instruction clock or pin rising edges
// RULE18: counting only while counter_on_bit set, count kept otherwise
// RULE19: wide access buffers high byte on low read and low write
// RULE20: only low byte writes clear the prescaler
// RULE21: overflow_flag set in the same cycle the count wraps
module sot_timer
   import sot_pkg::*;
(
   // system
   input wire logic clk_sys,
   input wire logic reset_n,
   // register bus
   input wire sot_apb_req_s apbReq,
   output sot_apb_rsp_s apbRsp,
   // crystal and external clock pins
   input wire logic oscInPin,
   input wire logic extClkPin,
   output logic oscRun,
   output logic oscLowPower,
   // configuration and power management
   input wire logic lowPowerOscConfig,
   input wire logic sleepExec,
   input wire logic wakeEvent,
   input wire logic clockFail,
   output logic sysClkSecondary,
   output logic cpuHalted,
   output logic periphHalted,
   // converter and interrupt
   input wire logic adcEnabled,
   output logic adcStart,
   output logic overflowIrq
);

   typedef struct packed {
      logic [7:0] ctrl;
      logic [15:0] count;
      logic [7:0] hiBuf;
      logic ovf;
      logic ien;
      logic [1:0] scs;
      logic idleOnSleep;
      logic [3:0] cmpMode;
      logic [15:0] cmpVal;
      sot_mode_e mode;
      logic adcStart;
      logic [31:0] prdata;
   } sot_state_s;

   sot_state_s st;
   sot_state_s next_st;

   logic pinSel;
   logic pinRise;
   logic rawTick;
   logic inc;
   logic asyncMode;
   logic match;
   logic wrAcc;
   logic rdSetup;
   logic wrLo;
   logic wrHi;
   logic cntWrite;
   logic mapped;
   logic secActive;

   ////////////////////////////////////////////////////////////////////
   // helpers

   function automatic logic isMapped(input logic [7:0] a);
      return a == OFF_CTRL || a == OFF_CNT_LO || a == OFF_CNT_HI ||
             a == OFF_FLAG || a == OFF_IEN || a == OFF_OSCCTL ||
             a == OFF_CMPMODE || a == OFF_CMPVAL;
   endfunction

   function automatic logic isSecondary(input sot_mode_e m);
      return m == MODE_SEC_RUN || m == MODE_SEC_IDLE;
   endfunction

   ////////////////////////////////////////////////////////////////////
   // count source

   // the crystal input is used when its oscillator runs [RULE17]
   assign pinSel = st.ctrl[CB_OSCEN] ? oscInPin : extClkPin;

   sot_pin_sync #(
      .STAGES(SYNC_STAGES)
   ) u_sync (
      .clk_sys(clk_sys),
      .reset_n(reset_n),
      .pinAsync(pinSel),
      .pinLevel(),
      .pinRise(pinRise)
   );

   // instruction clock or pin edge, only while on [RULE17] [RULE18]
   assign rawTick = st.ctrl[CB_ON] && (st.ctrl[CB_SRC] ? pinRise : 1'b1);

   sot_prescaler #(
      .WIDTH(PRESC_W)
   ) u_presc (
      .clk_sys(clk_sys),
      .reset_n(reset_n),
      .clear(wrLo), // [RULE20]
      .divSel(st.ctrl[CB_PS +: 2]),
      .tickIn(rawTick),
      .tickOut(inc)
   );

   ////////////////////////////////////////////////////////////////////
   // bus decode

   assign wrAcc = apbReq.psel && apbReq.penable && apbReq.pwrite;
   assign rdSetup = apbReq.psel && !apbReq.penable && !apbReq.pwrite;
   assign wrLo = wrAcc && apbReq.paddr == OFF_CNT_LO;
   assign wrHi = wrAcc && apbReq.paddr == OFF_CNT_HI;
   assign cntWrite = wrLo || wrHi;
   assign mapped = isMapped(apbReq.paddr);

   // the trigger is held off in asynchronous counter mode, where the
   // clear could land between pin edges unreliably [RULE12]
   assign asyncMode = st.ctrl[CB_SRC] && st.ctrl[CB_NOSYNC];
   assign match = inc && !asyncMode && st.cmpMode == CMP_SPECIAL &&
                  st.count == st.cmpVal; // [RULE10] [RULE13]

   assign secActive = isSecondary(st.mode);

   ////////////////////////////////////////////////////////////////////
   // next state

   always_comb
   begin
      next_st = st;
      next_st.adcStart = match && adcEnabled; // [RULE11]

      // flag write before the set, so a wrap in the same cycle wins
      if (wrAcc && apbReq.paddr == OFF_FLAG)
      begin
         next_st.ovf = st.ovf && apbReq.pwdata[FB_OVF];
      end

      if (match)
      begin
         next_st.count = COUNT_ZERO; // [RULE10] [RULE15]
      end
      else if (inc)
      begin
         next_st.count = st.count + 16'h0001; // [RULE7]
         if (st.count == COUNT_MAX)
         begin
            next_st.ovf = 1'b1; // [RULE8] [RULE21]
         end
      end

      // count writes come last so they beat the trigger [RULE14]
      if (wrLo)
      begin
         if (st.ctrl[CB_WIDE])
         begin
            next_st.count = {st.hiBuf, apbReq.pwdata[7:0]}; // [RULE19]
         end
         else
         begin
            next_st.count[7:0] = apbReq.pwdata[7:0];
         end
      end
      if (wrHi)
      begin
         if (st.ctrl[CB_WIDE])
         begin
            next_st.hiBuf = apbReq.pwdata[7:0]; // [RULE19]
         end
         else
         begin
            next_st.count[15:8] = apbReq.pwdata[7:0];
         end
      end

      if (wrAcc)
      begin
         case (apbReq.paddr)
            OFF_CTRL:
            begin
               // the active flag bit is read-only [RULE5]
               next_st.ctrl = apbReq.pwdata[7:0];
               next_st.ctrl[CB_ACT] = 1'b0;
            end
            OFF_IEN: next_st.ien = apbReq.pwdata[0];
            OFF_OSCCTL:
            begin
               next_st.scs = apbReq.pwdata[OB_SCS +: 2];
               next_st.idleOnSleep = apbReq.pwdata[OB_IDLE];
            end
            OFF_CMPMODE: next_st.cmpMode = apbReq.pwdata[3:0];
            OFF_CMPVAL: next_st.cmpVal = apbReq.pwdata[15:0];
            default: next_st.prdata = st.prdata;
         endcase
      end

      // read data is captured in the setup cycle
      if (rdSetup)
      begin
         next_st.prdata = '0;
         case (apbReq.paddr)
            OFF_CTRL:
            begin
               next_st.prdata[7:0] = st.ctrl;
               next_st.prdata[CB_ACT] = secActive; // [RULE5]
            end
            OFF_CNT_LO:
            begin
               next_st.prdata[7:0] = st.count[7:0];
               if (st.ctrl[CB_WIDE])
               begin
                  next_st.hiBuf = st.count[15:8]; // [RULE19]
               end
            end
            OFF_CNT_HI:
            begin
               next_st.prdata[7:0] = st.ctrl[CB_WIDE] ?
                                     st.hiBuf : st.count[15:8];
            end
            OFF_FLAG: next_st.prdata[FB_OVF] = st.ovf;
            OFF_IEN: next_st.prdata[0] = st.ien;
            OFF_OSCCTL:
            begin
               next_st.prdata[OB_SCS +: 2] = st.scs;
               next_st.prdata[OB_IDLE] = st.idleOnSleep;
            end
            OFF_CMPMODE: next_st.prdata[3:0] = st.cmpMode;
            OFF_CMPVAL: next_st.prdata[15:0] = st.cmpVal;
            default: next_st.prdata = '0;
         endcase
      end

      // power-managed clock modes; a failed secondary clock hands
      // the system back to the primary source at once
      case (st.mode)
         MODE_PRI:
         begin
            if (sleepExec)
            begin
               next_st.mode = MODE_SLEEP;
            end
            else if (st.scs == SCS_SECONDARY && !clockFail)
            begin
               next_st.mode = MODE_SEC_RUN; // [RULE3]
            end
         end
         MODE_SEC_RUN:
         begin
            if (clockFail || st.scs != SCS_SECONDARY)
            begin
               next_st.mode = MODE_PRI; // [RULE5]
            end
            else if (sleepExec)
            begin
               next_st.mode = st.idleOnSleep ?
                              MODE_SLEEP : MODE_SEC_IDLE; // [RULE4]
            end
         end
         MODE_SEC_IDLE:
         begin
            if (clockFail)
            begin
               next_st.mode = MODE_PRI;
            end
            else if (wakeEvent)
            begin
               next_st.mode = MODE_SEC_RUN;
            end
         end
         MODE_SLEEP:
         begin
            if (wakeEvent)
            begin
               next_st.mode = MODE_PRI;
            end
         end
         default: next_st.mode = MODE_PRI;
      endcase
   end

   always_ff @(posedge clk_sys or negedge reset_n)
   begin
      if (!reset_n)
      begin
         st <= '{mode: MODE_PRI, default: '0};
      end
      else
      begin
         st <= next_st;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // outputs

   // oscillator enable ignores the power mode on purpose [RULE1] [RULE2]
   assign oscRun = st.ctrl[CB_OSCEN];
   assign oscLowPower = lowPowerOscConfig; // [RULE6]
   assign sysClkSecondary = secActive; // [RULE3]
   assign cpuHalted = st.mode == MODE_SEC_IDLE || st.mode == MODE_SLEEP;
   assign periphHalted = st.mode == MODE_SLEEP;
   assign adcStart = st.adcStart;
   assign overflowIrq = st.ovf && st.ien; // [RULE9]
   assign apbRsp.pready = apbReq.psel && apbReq.penable;
   assign apbRsp.pslverr = apbRsp.pready && !mapped;
   assign apbRsp.prdata = st.prdata;

   ////////////////////////////////////////////////////////////////////
   // checks

   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!reset_n);

   sequence s_ctrlWrite;
      wrAcc && apbReq.paddr == OFF_CTRL;
   endsequence

   sequence s_halted;
      !st.ctrl[CB_ON] && !cntWrite;
   endsequence

   property p_oscEnable;
      s_ctrlWrite |=> oscRun == $past(apbReq.pwdata[CB_OSCEN]);
   endproperty
   a_oscEnable: assert property (p_oscEnable) // [RULE1]
      else $error("oscillator enable does not follow the control write");

   property p_oscModes;
      !(wrAcc && apbReq.paddr == OFF_CTRL) && st.mode != next_st.mode
         |=> $stable(oscRun);
   endproperty
   a_oscModes: assert property (p_oscModes) // [RULE2]
      else $error("oscillator gated by a mode change");

   property p_secRun;
      st.mode == MODE_PRI && st.scs == SCS_SECONDARY && !sleepExec &&
         !clockFail |=> sysClkSecondary && st.mode == MODE_SEC_RUN;
   endproperty
   a_secRun: assert property (p_secRun) // [RULE3]
      else $error("secondary run not entered");

   property p_secIdle;
      st.mode == MODE_SEC_RUN && sleepExec && !st.idleOnSleep &&
         !clockFail && st.scs == SCS_SECONDARY |=> cpuHalted && secActive;
   endproperty
   a_secIdle: assert property (p_secIdle) // [RULE4]
      else $error("secondary idle not entered");

   property p_failover;
      clockFail |=> !sysClkSecondary;
   endproperty
   a_failover: assert property (p_failover) // [RULE5]
      else $error("active flag still set after clock failure");

   property p_wrap;
      inc && !match && st.count == COUNT_MAX && !cntWrite
         |=> st.count == COUNT_ZERO && st.ovf;
   endproperty
   a_wrap: assert property (p_wrap) // [RULE8]
      else $error("wrap did not clear count and set flag together");

   property p_irqMask;
      !st.ien |-> !overflowIrq;
   endproperty
   a_irqMask: assert property (p_irqMask) // [RULE9]
      else $error("interrupt raised while masked");

   property p_trigClear;
      match && !cntWrite && !(wrAcc && apbReq.paddr == OFF_FLAG)
         |=> st.count == COUNT_ZERO && st.ovf == $past(st.ovf);
   endproperty
   a_trigClear: assert property (p_trigClear) // [RULE15]
      else $error("trigger clear wrong or touched the flag");

   // a zero period matches on every tick, so starts may then run together
   property p_trigAdc;
      match && st.cmpVal != COUNT_ZERO
         |=> adcStart == $past(adcEnabled) ##1 !adcStart;
   endproperty
   a_trigAdc: assert property (p_trigAdc) // [RULE11]
      else $error("conversion start does not follow the trigger");

   property p_writeWins;
      match && wrLo |=> st.count[7:0] == $past(apbReq.pwdata[7:0]);
   endproperty
   a_writeWins: assert property (p_writeWins) // [RULE14]
      else $error("trigger clear beat a count write");

   property p_halt;
      s_halted |=> $stable(st.count);
   endproperty
   a_halt: assert property (p_halt) // [RULE18]
      else $error("count moved while stopped");

endmodule

// ==== verif/sot_osc_model.sv ====
// model crystal and external clock source at the timer's pins
// assumes oscRun powers the crystal amplifier and extRun is set by the bench
module sot_osc_model
#(
   parameter int XTAL_HALF_NS = 153,
   parameter int EXT_HALF_NS = 117
)
(
   // control
   input wire logic oscRun,
   input wire logic extRun,
   // pins
   output logic oscInPin,
   output logic extClkPin
);
   timeunit 1ns;
   timeprecision 1ps;

   initial
   begin
      oscInPin = 1'b0;
      extClkPin = 1'b0;
   end

   ////////////////////////////////////////////////////////////////////////
   // crystal swings only while its amplifier is powered, whatever the mode
   always
   begin
      #(XTAL_HALF_NS);
      if (oscRun === 1'b1) oscInPin = ~oscInPin;
      else oscInPin = 1'b0;
   end

   // external clock stands still low between bursts
   always
   begin
      #(EXT_HALF_NS);
      if (extRun === 1'b1) extClkPin = ~extClkPin;
      else extClkPin = 1'b0;
   end
endmodule

// ==== verif/sot_timer_tb_top.sv ====
// self-checking bench for the secondary oscillator timer
// assumes the pin model sits on oscInPin and extClkPin
module sot_timer_tb_top
   import sot_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;

   typedef struct packed {
      logic [7:0] addr;
      logic [31:0] wd;
      logic [31:0] rd;
      logic err;
   } sot_row_s;

   logic clk_sys = 1'b0;
   logic reset_n, lowPowerOscConfig, sleepExec, wakeEvent, clockFail;
   logic adcEnabled, extRun, oscInPin, extClkPin, oscRun, oscLowPower;
   logic sysClkSecondary, cpuHalted, periphHalted, adcStart, overflowIrq;
   logic errSeen, prevAdc;
   logic [31:0] rdData, lo;
   sot_apb_req_s apbReq;
   sot_apb_rsp_s apbRsp;
   int failCount = 0;
   int totalChecks = 0;
   int adcHigh, adcRise;
   int cycles = 0;
   sot_row_s rows [9] = '{
      '{OFF_CNT_LO, 32'ha5, 32'ha5, 1'b0},
      '{OFF_CNT_HI, 32'h5a, 32'h5a, 1'b0},
      '{OFF_FLAG, 32'h1, 32'h0, 1'b0},
      '{OFF_IEN, 32'h1, 32'h1, 1'b0},
      '{OFF_OSCCTL, 32'h80, 32'h80, 1'b0},
      '{OFF_CMPMODE, 32'hb, 32'hb, 1'b0},
      '{OFF_CMPVAL, 32'hbeef, 32'hbeef, 1'b0},
      '{8'h20, 32'hff, 32'h0, 1'b1},
      '{OFF_CTRL, 32'hf6, 32'hb6, 1'b0}};

   always #10 clk_sys = ~clk_sys;

   sot_timer DUT (.clk_sys(clk_sys), .reset_n(reset_n), .apbReq(apbReq),
      .apbRsp(apbRsp), .oscInPin(oscInPin), .extClkPin(extClkPin),
      .oscRun(oscRun), .oscLowPower(oscLowPower),
      .lowPowerOscConfig(lowPowerOscConfig), .sleepExec(sleepExec),
      .wakeEvent(wakeEvent), .clockFail(clockFail),
      .sysClkSecondary(sysClkSecondary), .cpuHalted(cpuHalted),
      .periphHalted(periphHalted), .adcEnabled(adcEnabled),
      .adcStart(adcStart), .overflowIrq(overflowIrq));

   sot_osc_model pins (.oscRun(oscRun), .extRun(extRun),
      .oscInPin(oscInPin), .extClkPin(extClkPin));

   ////////////////////////////////////////////////////////////////////////
   task automatic finalReport;
      $display("checks %0d mismatches %0d", totalChecks, failCount);
      if (failCount == 0 && totalChecks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   task automatic check(input string nm, input logic [31:0] seen,
                        input logic [31:0] exp);
      totalChecks++;
      if (seen !== exp)
      begin
         failCount++;
         $display("mismatch %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   // one APB transfer; waits for pready however long the slave takes
   task automatic apb(input logic wr, input logic [7:0] a,
                      input logic [31:0] d);
      @(posedge clk_sys);
      apbReq <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a,
                  pwdata: d};
      @(posedge clk_sys);
      apbReq.penable <= 1'b1;
      // only the bench watchdog ends a wait that never gets pready
      do
      begin
         @(posedge clk_sys);
      end
      while (apbRsp.pready !== 1'b1);
      rdData = apbRsp.prdata;
      errSeen = apbRsp.pslverr;
      apbReq <= '0;
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge clk_sys);
   endtask

   task automatic pulse(input logic isWake);
      @(posedge clk_sys);
      if (isWake) wakeEvent <= 1'b1;
      else sleepExec <= 1'b1;
      @(posedge clk_sys);
      wakeEvent <= 1'b0;
      sleepExec <= 1'b0;
      cyc(3);
   endtask

   // clear count, run a burst of external clock, leave count in rdData
   task automatic extCount(input logic [31:0] ctl);
      apb(1'b1, OFF_CNT_HI, 32'h0);
      apb(1'b1, OFF_CNT_LO, 32'h0);
      apb(1'b1, OFF_CTRL, ctl);
      extRun <= 1'b1;
      cyc(117);
      extRun <= 1'b0;
      cyc(10);
      apb(1'b1, OFF_CTRL, 32'h0);
      apb(1'b0, OFF_CNT_LO, 32'h0);
   endtask

   ////////////////////////////////////////////////////////////////////////
   always @(posedge clk_sys)
   begin
      cycles++;
      if (adcStart === 1'b1) adcHigh++;
      if (adcStart === 1'b1 && prevAdc !== 1'b1) adcRise++;
      prevAdc <= adcStart;
      if (cycles == 20000)
      begin
         failCount++;
         finalReport();
      end
   end

   initial
   begin
      apbReq = '0;
      {reset_n, lowPowerOscConfig, sleepExec, wakeEvent} = 4'h0;
      {clockFail, adcEnabled, extRun} = 3'h0;
      cyc(2);
      reset_n <= 1'b1;
      foreach (rows[i])
      begin
         apb(1'b0, rows[i].addr, 32'h0);
         check("reset", rdData, 32'h0);
      end
      foreach (rows[i])
      begin
         apb(1'b1, rows[i].addr, rows[i].wd);
         apb(1'b0, rows[i].addr, 32'h0);
         check("reg", rdData, rows[i].rd);
         check("err", 32'(errSeen), 32'(rows[i].err));
      end
      apb(1'b0, OFF_CNT_LO, 32'h0);
      apb(1'b1, OFF_CNT_HI, 32'h12);
      apb(1'b1, OFF_CNT_LO, 32'h34);
      apb(1'b0, OFF_CNT_LO, 32'h0);
      apb(1'b0, OFF_CNT_HI, 32'h0);
      check("wide_hi", rdData, 32'h12);
      apb(1'b1, OFF_CTRL, 32'h0);
      apb(1'b1, OFF_OSCCTL, 32'h0);
      apb(1'b1, OFF_CMPMODE, 32'h0);
      // wrap from fffd with the interrupt enabled
      apb(1'b1, OFF_CNT_HI, 32'hff);
      apb(1'b1, OFF_CNT_LO, 32'hfd);
      apb(1'b1, OFF_CTRL, 32'h1);
      cyc(8);
      apb(1'b1, OFF_CTRL, 32'h0);
      apb(1'b0, OFF_FLAG, 32'h0);
      check("ovf_flag", rdData, 32'h1);
      check("irq_on", 32'(overflowIrq), 32'h1);
      apb(1'b0, OFF_CNT_HI, 32'h0);
      check("wrap_hi", rdData, 32'h0);
      apb(1'b0, OFF_CNT_LO, 32'h0);
      lo = rdData;
      check("wrap_lo", 32'(lo > 0 && lo < 32'h10), 32'h1);
      cyc(5);
      apb(1'b0, OFF_CNT_LO, 32'h0);
      check("hold", rdData, lo);
      apb(1'b1, OFF_IEN, 32'h0);
      cyc(1);
      check("irq_mask", 32'(overflowIrq), 32'h0);
      apb(1'b0, OFF_FLAG, 32'h0);
      check("flag_kept", rdData, 32'h1);
      apb(1'b1, OFF_FLAG, 32'h0);
      apb(1'b0, OFF_FLAG, 32'h0);
      check("flag_clr", rdData, 32'h0);
      // compare period 5 with converter start pulses
      apb(1'b1, OFF_CNT_LO, 32'h0);
      apb(1'b1, OFF_CMPVAL, 32'h5);
      apb(1'b1, OFF_CMPMODE, 32'hb);
      adcEnabled <= 1'b1;
      adcHigh = 0;
      adcRise = 0;
      apb(1'b1, OFF_CTRL, 32'h1);
      cyc(40);
      apb(1'b1, OFF_CTRL, 32'h0);
      apb(1'b0, OFF_CNT_LO, 32'h0);
      check("period", 32'(rdData <= 32'h5), 32'h1);
      check("adc_start", 32'(adcRise >= 4), 32'h1);
      check("adc_width", adcHigh, adcRise);
      adcEnabled <= 1'b0;
      adcRise = 0;
      apb(1'b1, OFF_CTRL, 32'h1);
      cyc(20);
      apb(1'b1, OFF_CTRL, 32'h0);
      check("adc_off", adcRise, 32'h0);
      // match at ffff clears without a flag
      apb(1'b1, OFF_CMPVAL, 32'hffff);
      apb(1'b1, OFF_CNT_HI, 32'hff);
      apb(1'b1, OFF_CNT_LO, 32'hfa);
      apb(1'b1, OFF_CTRL, 32'h1);
      cyc(12);
      apb(1'b1, OFF_CTRL, 32'h0);
      apb(1'b0, OFF_FLAG, 32'h0);
      check("trig_noflag", rdData, 32'h0);
      // count is 5 at the edge that takes the low-byte write
      apb(1'b1, OFF_CMPVAL, 32'h5);
      apb(1'b1, OFF_CNT_HI, 32'h0);
      apb(1'b1, OFF_CNT_LO, 32'h3);
      apb(1'b1, OFF_CTRL, 32'h1);
      apb(1'b1, OFF_CNT_LO, 32'h40);
      apb(1'b1, OFF_CTRL, 32'h0);
      apb(1'b0, OFF_CNT_LO, 32'h0);
      check("write_wins", rdData, 32'h43);
      // external pin: synchronous, asynchronous, plain count
      apb(1'b1, OFF_CMPVAL, 32'h2);
      extCount(32'h3);
      check("sync_clear", 32'(rdData <= 32'h2), 32'h1);
      extCount(32'h7);
      check("async", 32'(rdData > 32'h2), 32'h1);
      apb(1'b1, OFF_CMPMODE, 32'h0);
      extCount(32'h3);
      check("ext_cnt", 32'(rdData >= 8 && rdData <= 11), 32'h1);
      // crystal: let it start before counting on it
      apb(1'b1, OFF_CTRL, 32'h8);
      cyc(20);
      check("osc_on", 32'(oscRun), 32'h1);
      apb(1'b1, OFF_CNT_LO, 32'h0);
      apb(1'b1, OFF_CTRL, 32'hb);
      cyc(100);
      apb(1'b1, OFF_CTRL, 32'h8);
      apb(1'b0, OFF_CNT_LO, 32'h0);
      check("xtal_cnt", 32'(rdData >= 5 && rdData <= 8), 32'h1);
      // power-managed modes
      lowPowerOscConfig <= 1'b1;
      cyc(1);
      check("lp_on", 32'(oscLowPower), 32'h1);
      lowPowerOscConfig <= 1'b0;
      cyc(1);
      check("lp_off", 32'(oscLowPower), 32'h0);
      apb(1'b1, OFF_OSCCTL, 32'h1);
      cyc(3);
      check("sec_run", 32'(sysClkSecondary), 32'h1);
      apb(1'b0, OFF_CTRL, 32'h0);
      check("active", 32'(rdData[CB_ACT]), 32'h1);
      pulse(1'b0);
      check("idle_cpu", {cpuHalted, periphHalted}, 32'h2);
      check("idle_osc", 32'(oscRun), 32'h1);
      pulse(1'b1);
      check("idle_wake", 32'(cpuHalted), 32'h0);
      apb(1'b1, OFF_OSCCTL, 32'h81);
      pulse(1'b0);
      check("sleep", 32'(periphHalted), 32'h1);
      check("sleep_osc", 32'(oscRun), 32'h1);
      pulse(1'b1);
      clockFail <= 1'b1;
      cyc(3);
      check("failover", 32'(sysClkSecondary), 32'h0);
      apb(1'b0, OFF_CTRL, 32'h0);
      check("fail_act", 32'(rdData[CB_ACT]), 32'h0);
      clockFail <= 1'b0;
      apb(1'b1, OFF_CTRL, 32'h0);
      cyc(1);
      check("osc_off", 32'(oscRun), 32'h0);
      finalReport();
   end
endmodule
